// ---- sar_adc_pkg.sv ----
package sar_adc_pkg;
	// Register byte addresses on the bus
	localparam logic [7:0] OFS_INPUT_SELECT = 8'h00;
	localparam logic [7:0] OFS_CONTROL_A = 8'h04;
	localparam logic [7:0] OFS_CONTROL_B = 8'h08;
	localparam logic [7:0] OFS_RESULT_LOW = 8'h0c;
	localparam logic [7:0] OFS_RESULT_HIGH = 8'h10;
	localparam logic [7:0] OFS_POWER_REDUCTION = 8'h14;
	// Field positions
	localparam int CHAN_LSB = 0;
	localparam int LEFT_BIT = 5;
	localparam int REF_LSB = 6;
	localparam int ENABLE_BIT = 7;
	localparam int START_BIT = 6;
	localparam int AUTO_BIT = 5;
	localparam int FLAG_BIT = 4;
	localparam int DIV_LSB = 0;
	localparam int TRIG_LSB = 0;
	localparam int PWR_BIT = 0;
	// Values after reset
	localparam logic [3:0] RST_CHANNEL = 4'h0;
	localparam logic [1:0] RST_REFERENCE = 2'h0;
	localparam logic [2:0] RST_DIVIDER = 3'h0;
	localparam logic [2:0] RST_TRIGGER = 3'h0;
	localparam logic RST_POWER_REDUCTION = 1'b0;
	// Channel codes beyond the eight pins
	localparam logic [3:0] CHAN_BANDGAP = 4'he;
	localparam logic [3:0] CHAN_GROUND = 4'hf;
	// Trigger source code that means the own done flag
	localparam logic [2:0] SRC_DONE_FLAG = 3'h0;
	// Converter clock cycle indices (count from 0)
	localparam logic [4:0] NORMAL_SH_IDX = 5'h01;
	localparam logic [4:0] NORMAL_LAST_IDX = 5'h0c;
	localparam logic [4:0] FIRST_SH_IDX = 5'h0d;
	localparam logic [4:0] FIRST_LAST_IDX = 5'h18;
	localparam logic [4:0] AUTO_SH_IDX = 5'h01;
	localparam logic [4:0] AUTO_LAST_IDX = 5'h0d;
	// Processor cycles spent synchronising a trigger edge
	localparam int TRIG_SYNC_CYCLES = 3;
	// Conversion sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_CONV = 3'b100
	} state_t;
endpackage

// ---- sar_adc_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module sar_adc_ctrl (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Internal trigger sources, bit 0 unused
	input wire logic [7:0] trigger_sources_i,
	// Analog core
	input wire logic comparator_i,
	output logic converter_power_o,
	output logic [3:0] channel_select_o,
	output logic [1:0] reference_select_o,
	output logic sample_hold_o,
	output logic [9:0] dac_code_o,
	output logic conversion_done_o
);
	import sar_adc_pkg::*;

	typedef struct packed {
		state_t st;
		logic [7:0] cnt;
		logic [4:0] idx;
		logic cur_first;
		logic cur_auto;
		logic first;
		logic enable;
		logic start;
		logic auto_en;
		logic flag;
		logic pwr_red;
		logic power;
		logic [2:0] div_sel;
		logic [2:0] trig_sel;
		logic [3:0] live_chan;
		logic [1:0] live_ref;
		logic left;
		logic [3:0] app_chan;
		logic [1:0] app_ref;
		logic [9:0] sar;
		logic [9:0] mask;
		logic [9:0] result;
		logic lock;
		logic sh;
		logic trig_prev;
		logic [TRIG_SYNC_CYCLES-1:0] trig_pipe;
		logic comp_s1;
		logic comp_s2;
		logic ack;
		logic [31:0] rdata;
	} state_reg_t;

	state_reg_t s;
	state_reg_t next_s;

	logic eff_en;
	logic [7:0] presc_last;
	logic [7:0] presc_half;
	logic tick;
	logic half;
	logic conv;
	logic [4:0] last_idx;
	logic [4:0] sh_idx;
	logic sample_now;
	logic done_now;
	logic last_cycle;
	logic freerun;
	logic trig_level;
	logic trig_edge;
	logic auto_start;
	logic req;
	logic wr;
	logic rd;
	logic start_req;
	logic next_power;
	logic [7:0] res_low;
	logic [7:0] res_high;
	logic [7:0] rd_byte;

	// Prescaler divides by 2 to 256 in powers of two
	assign eff_en = s.enable & ~s.pwr_red;
	assign presc_last = 8'hff >> (3'h7 - s.div_sel);
	assign presc_half = presc_last >> 1;
	assign tick = eff_en & (s.cnt == presc_last);
	assign half = eff_en & (s.cnt == presc_half);

	// Conversion timing depends on how it was started
	assign conv = (s.st == ST_CONV);
	assign last_idx = s.cur_auto ? AUTO_LAST_IDX :
		(s.cur_first ? FIRST_LAST_IDX : NORMAL_LAST_IDX);
	assign sh_idx = s.cur_auto ? AUTO_SH_IDX :
		(s.cur_first ? FIRST_SH_IDX : NORMAL_SH_IDX);
	// Auto mode samples on a full edge and ends on a half cycle
	assign sample_now = conv & (s.cur_auto ? tick : half) & (s.idx == sh_idx);
	assign done_now = conv & (s.cur_auto ? half : tick) & (s.idx == last_idx);
	assign last_cycle = conv & (s.idx == last_idx);

	// Trigger selection and edge detection
	assign freerun = s.auto_en & (s.trig_sel == SRC_DONE_FLAG);
	assign trig_level = (s.trig_sel == SRC_DONE_FLAG) ? s.flag :
		trigger_sources_i[s.trig_sel];
	// Own-flag source is handled by the free-running path instead
	assign trig_edge = trig_level & ~s.trig_prev & s.auto_en &
		(s.trig_sel != SRC_DONE_FLAG);
	// Edges landing mid-conversion are simply dropped
	assign auto_start = s.trig_pipe[TRIG_SYNC_CYCLES-1] & eff_en & s.auto_en &
		(s.st != ST_CONV);

	// Bus decode
	assign req = wb_cyc_i & wb_stb_i & ~s.ack;
	assign wr = req & wb_we_i & wb_sel_i[0];
	assign rd = req & ~wb_we_i;
	// Start needs enable and cleared power reduction in the same write
	assign start_req = wr & (wb_adr_i == OFS_CONTROL_A) & wb_dat_i[START_BIT] &
		wb_dat_i[ENABLE_BIT] & ~s.pwr_red;

	// Result byte formatting
	assign res_low = s.left ? {s.result[1:0], 6'h00} : s.result[7:0];
	assign res_high = s.left ? s.result[9:2] : {6'h00, s.result[9:8]};

	// Read multiplexer; unmapped addresses read zero
	always_comb begin
		rd_byte = 8'h00;
		unique case (wb_adr_i)
			OFS_INPUT_SELECT: rd_byte = {s.live_ref, s.left, 1'b0, s.live_chan};
			OFS_CONTROL_A: rd_byte = {s.enable, s.start, s.auto_en, s.flag, 1'b0,
				s.div_sel};
			OFS_CONTROL_B: rd_byte = {5'h00, s.trig_sel};
			OFS_RESULT_LOW: rd_byte = res_low;
			OFS_RESULT_HIGH: rd_byte = res_high;
			OFS_POWER_REDUCTION: rd_byte = {7'h00, s.pwr_red};
			default: rd_byte = 8'h00;
		endcase
	end

	// Next-state logic for the whole block
	always_comb begin
		next_s = s;
		next_power = 1'b0;
		next_s.sh = 1'b0;
		next_s.ack = req;
		next_s.comp_s1 = comparator_i;
		next_s.comp_s2 = s.comp_s1;
		next_s.trig_prev = trig_level;
		next_s.trig_pipe = {s.trig_pipe[TRIG_SYNC_CYCLES-2:0], trig_edge};
		if (rd) begin
			next_s.rdata = {24'h000000, rd_byte};
		end
		// Register writes
		if (wr) begin
			unique case (wb_adr_i)
				OFS_INPUT_SELECT: begin
					next_s.live_chan = wb_dat_i[CHAN_LSB +: 4];
					next_s.live_ref = wb_dat_i[REF_LSB +: 2];
					next_s.left = wb_dat_i[LEFT_BIT];
				end
				OFS_CONTROL_A: begin
					next_s.enable = wb_dat_i[ENABLE_BIT];
					next_s.auto_en = wb_dat_i[AUTO_BIT];
					next_s.div_sel = wb_dat_i[DIV_LSB +: 3];
				end
				OFS_CONTROL_B: next_s.trig_sel = wb_dat_i[TRIG_LSB +: 3];
				OFS_POWER_REDUCTION: next_s.pwr_red = wb_dat_i[PWR_BIT];
				default: begin
				end
			endcase
		end
		// Done flag: write one clears, a completion in the same cycle wins
		if (wr && wb_adr_i == OFS_CONTROL_A && wb_dat_i[FLAG_BIT]) begin
			next_s.flag = 1'b0;
		end
		if (done_now) begin
			next_s.flag = 1'b1;
		end
		// Result lock: low read locks, high read releases
		if (rd && wb_adr_i == OFS_RESULT_LOW) begin
			next_s.lock = 1'b1;
		end
		if (rd && wb_adr_i == OFS_RESULT_HIGH) begin
			next_s.lock = 1'b0;
		end
		if (done_now && !s.lock) begin
			next_s.result = s.sar;
		end
		// Prescaler free-runs while enabled
		next_s.cnt = tick ? 8'h00 : s.cnt + 8'h01;
		if (conv && tick) begin
			next_s.idx = s.idx + 5'h01;
		end
		// Successive approximation: comparator high keeps the trial bit
		// Synchroniser lag: ratios below 8, or below 4 in auto mode, decide on stale comparator values
		if (sample_now) begin
			next_s.sh = 1'b1;
			next_s.sar = 10'h200;
			next_s.mask = 10'h200;
		end else if (conv && tick && s.mask != 10'h000) begin
			next_s.sar = (s.comp_s2 ? s.sar : (s.sar & ~s.mask)) | (s.mask >> 1);
			next_s.mask = s.mask >> 1;
		end
		// Conversion sequencer
		unique case (s.st)
			ST_IDLE: begin
				if (auto_start) begin
					next_s.st = ST_CONV;
					next_s.cnt = 8'h00;
					next_s.idx = 5'h00;
					next_s.cur_auto = 1'b1;
					next_s.cur_first = 1'b0;
					next_s.first = 1'b0;
					next_s.start = 1'b1;
				end else if (start_req) begin
					next_s.st = ST_WAIT;
					next_s.start = 1'b1;
				end
			end
			ST_WAIT: begin
				if (auto_start) begin
					next_s.st = ST_CONV;
					next_s.cnt = 8'h00;
					next_s.idx = 5'h00;
					next_s.cur_auto = 1'b1;
					next_s.cur_first = 1'b0;
					next_s.first = 1'b0;
					next_s.start = 1'b1;
				end else if (tick) begin
					next_s.st = ST_CONV;
					next_s.idx = 5'h00;
					next_s.cur_auto = 1'b0;
					next_s.cur_first = s.first;
					next_s.first = 1'b0;
				end
			end
			ST_CONV: begin
				if (done_now && freerun) begin
					next_s.idx = 5'h00;
					next_s.cur_auto = 1'b0;
					next_s.cur_first = 1'b0;
				end else if (done_now) begin
					next_s.st = ST_IDLE;
					next_s.start = 1'b0;
				end
			end
		endcase
		// Selection buffer tracks outside conversions and in the last cycle
		if (!conv || last_cycle) begin
			next_s.app_chan = s.live_chan;
			next_s.app_ref = s.live_ref;
		end
		// Disable aborts any conversion and holds the prescaler in reset; flag, result and lock keep their values
		next_power = next_s.enable & ~next_s.pwr_red;
		next_s.power = next_power;
		if (!next_power) begin
			next_s.st = ST_IDLE;
			next_s.start = 1'b0;
			next_s.cnt = 8'h00;
			next_s.idx = 5'h00;
			next_s.first = 1'b1;
			next_s.mask = 10'h000;
			next_s.app_chan = RST_CHANNEL;
			next_s.app_ref = RST_REFERENCE;
		end
	end

	// Single state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.st <= ST_IDLE;
			s.first <= 1'b1;
			s.pwr_red <= RST_POWER_REDUCTION;
			s.div_sel <= RST_DIVIDER;
			s.trig_sel <= RST_TRIGGER;
			s.live_chan <= RST_CHANNEL;
			s.live_ref <= RST_REFERENCE;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from flops
	assign wb_dat_o = s.rdata;
	assign wb_ack_o = s.ack;
	assign converter_power_o = s.power;
	assign channel_select_o = s.app_chan;
	assign reference_select_o = s.app_ref;
	assign sample_hold_o = s.sh;
	assign dac_code_o = s.sar;
	assign conversion_done_o = s.flag;

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_power_gates_sel: assert property (!converter_power_o |->
		channel_select_o == 4'h0 && reference_select_o == 2'h0)
		else $error("selection applied while converter off");
	a_busy_reads_start: assert property (conv |-> s.start)
		else $error("start bit low during conversion");
	a_lock_keeps_res: assert property (done_now && s.lock |=> $stable(s.result))
		else $error("locked result overwritten");
	a_flag_when_lost: assert property (done_now && s.lock && eff_en |=> s.flag)
		else $error("done flag missing on discarded result");
	a_single_clears: assert property (done_now && !freerun && s.enable |=>
		!s.start && s.st == ST_IDLE)
		else $error("start bit not cleared at completion");
	a_free_restart: assert property (done_now && freerun && next_power |=>
		conv && s.start && s.idx == 5'h00)
		else $error("free running did not restart");
	a_presc_held: assert property (!eff_en |-> s.cnt == 8'h00 || $past(eff_en))
		else $error("prescaler running while disabled");
	a_sel_frozen: assert property (conv && !last_cycle |=>
		$stable(s.app_chan) || !s.power)
		else $error("channel changed mid conversion");
	a_trig_start: assert property (auto_start && next_power |=>
		conv && s.cnt == 8'h00 && s.cur_auto)
		else $error("trigger did not start conversion");
	a_tick_start: assert property (s.st == ST_WAIT && tick && !auto_start &&
		next_power |=> conv && s.idx == 5'h00)
		else $error("start not on converter edge");

	c_done: cover property (done_now);
	c_free_run: cover property (done_now && freerun);
	c_lost_result: cover property (done_now && s.lock);
	c_auto_start: cover property (auto_start);
endmodule
`default_nettype wire

// ---- analog_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module analog_core_model (
	// Converter side
	input wire logic clk_i,
	input wire logic power_i,
	input wire logic [3:0] channel_select_i,
	input wire logic sample_hold_i,
	input wire logic [9:0] dac_code_i,
	// Decision back to the block
	output logic comparator_o
);
	logic [9:0] held = 10'h000;
	// Level per input: channel code in the top nibble keeps inputs apart
	always @(posedge clk_i) begin
		if (sample_hold_i === 1'b1) begin
			held <= (channel_select_i == 4'hf) ? 10'h000 : {channel_select_i, 6'h2b};
		end
	end
	// Unpowered core reads low, never a stale decision
	assign comparator_o = power_i && (held >= dac_code_i);
endmodule
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import sar_adc_pkg::*;
	typedef struct packed {logic [7:0] adr; logic we; logic [7:0] wd; logic [31:0] exp;} row_t;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [7:0] trig = 8'h00;
	logic [31:0] q;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, comparator, power, sample_hold_o, conversion_done_o;
	logic [3:0] channel_select_o;
	logic [1:0] reference_select_o;
	logic [9:0] dac_code;
	int n_mismatch = 0;
	int comparisons = 0;
	int sh_count = 0;
	row_t rows [12] = '{
		'{8'h00, 1'b0, 8'h00, 32'h0}, '{8'h04, 1'b0, 8'h00, 32'h0},
		'{8'h08, 1'b0, 8'h00, 32'h0}, '{8'h0c, 1'b0, 8'h00, 32'h0},
		'{8'h10, 1'b0, 8'h00, 32'h0}, '{8'h14, 1'b0, 8'h00, 32'h0},
		'{8'h08, 1'b1, 8'h05, 32'h0}, '{8'h08, 1'b0, 8'h00, 32'h5},
		'{8'h18, 1'b1, 8'hff, 32'h0}, '{8'h18, 1'b0, 8'h00, 32'h0},
		'{8'h00, 1'b1, 8'h45, 32'h0}, '{8'h00, 1'b0, 8'h00, 32'h45}};
	// 20 MHz clock
	always #25 clk_i = ~clk_i;
	always @(posedge clk_i) if (sample_hold_o === 1'b1) sh_count <= sh_count + 1;
	sar_adc_ctrl sar_adc_ctrl_inst (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .trigger_sources_i(trig), .comparator_i(comparator),
		.converter_power_o(power), .channel_select_o(channel_select_o),
		.reference_select_o(reference_select_o), .sample_hold_o(sample_hold_o),
		.dac_code_o(dac_code), .conversion_done_o(conversion_done_o));
	analog_core_model analog_core_model_inst (
		.clk_i(clk_i), .power_i(power), .channel_select_i(channel_select_o),
		.sample_hold_i(sample_hold_o), .dac_code_i(dac_code), .comparator_o(comparator));
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Classic cycle: hold everything until ack is sampled, then drop for a cycle
	task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) n_mismatch++;
		q = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wait_done(output int n);
		n = 0;
		while (conversion_done_o !== 1'b1 && n < 7000) begin
			@(posedge clk_i);
			n++;
		end
	endtask
	task automatic complete_run;
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Bound well above the whole sequence, about 21000 cycles
	initial begin
		repeat (40000) @(posedge clk_i);
		n_mismatch++;
		complete_run();
	end
	initial begin
		int n;
		int s0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (rows[i]) begin
			wb(rows[i].adr, rows[i].we, rows[i].wd);
			if (!rows[i].we) check("reg_read", q, rows[i].exp);
		end
		check("chan_off", channel_select_o, 4'h0);
		check("power_off", power, 1'b0);
		// First conversion after enable; divider 6 gives 156 kHz, full resolution
		wb(OFS_CONTROL_A, 1'b1, 8'h86);
		@(posedge clk_i);
		check("chan_on", channel_select_o, 4'h5);
		check("ref_on", reference_select_o, 2'h1);
		wb(OFS_CONTROL_A, 1'b1, 8'hc6);
		wb(OFS_CONTROL_A, 1'b0, 8'h00);
		check("start_busy", q, 32'hc6);
		wait_done(n);
		check("first_time", n >= 3198 && n <= 3325, 1'b1);
		wb(OFS_CONTROL_A, 1'b0, 8'h00);
		check("done_ctrl", q, 32'h96);
		wb(OFS_RESULT_LOW, 1'b0, 8'h00);
		check("low_r", q, 32'h6b);
		wb(OFS_RESULT_HIGH, 1'b0, 8'h00);
		check("high_r", q, 32'h01);
		// Channel change while converting must wait for the end
		wb(OFS_INPUT_SELECT, 1'b1, 8'h03);
		wb(OFS_CONTROL_A, 1'b1, 8'hd6);
		// Past the longest wait for the converter edge
		repeat (140) @(posedge clk_i);
		wb(OFS_INPUT_SELECT, 1'b1, 8'h06);
		check("chan_frozen", channel_select_o, 4'h3);
		wait_done(n);
		check("normal_time", n >= 1522 && n <= 1649, 1'b1);
		wb(OFS_RESULT_LOW, 1'b0, 8'h00);
		check("low_old", q, 32'heb);
		wb(OFS_RESULT_HIGH, 1'b0, 8'h00);
		// Low read locks; next result is dropped but still flagged
		wb(OFS_CONTROL_A, 1'b1, 8'h96);
		wb(OFS_RESULT_LOW, 1'b0, 8'h00);
		wb(OFS_CONTROL_A, 1'b1, 8'hc6);
		wait_done(n);
		check("flag_lost", conversion_done_o, 1'b1);
		wb(OFS_RESULT_HIGH, 1'b0, 8'h00);
		check("high_lock", q, 32'h00);
		wb(OFS_RESULT_LOW, 1'b0, 8'h00);
		check("low_lock", q, 32'heb);
		wb(OFS_RESULT_HIGH, 1'b0, 8'h00);
		// Auto trigger on source 2, left aligned
		wb(OFS_INPUT_SELECT, 1'b1, 8'h25);
		wb(OFS_CONTROL_B, 1'b1, 8'h02);
		wb(OFS_CONTROL_A, 1'b1, 8'hb6);
		@(posedge clk_i);
		trig <= 8'h04;
		repeat (12) @(posedge clk_i);
		trig <= 8'h00;
		@(posedge clk_i);
		trig <= 8'h04;
		wait_done(n);
		// 3 sync clocks, then 13.5 converter cycles of 128 clocks
		check("auto_time", n >= 1716 && n <= 1724, 1'b1);
		wb(OFS_CONTROL_A, 1'b1, 8'hb6);
		repeat (2000) @(posedge clk_i);
		check("no_retrig", conversion_done_o, 1'b0);
		wb(OFS_RESULT_LOW, 1'b0, 8'h00);
		check("low_l", q, 32'hc0);
		wb(OFS_RESULT_HIGH, 1'b0, 8'h00);
		check("high_l", q, 32'h5a);
		// Free running on the own done flag
		trig <= 8'h00;
		wb(OFS_CONTROL_B, 1'b1, SRC_DONE_FLAG);
		wb(OFS_CONTROL_A, 1'b1, 8'hf6);
		s0 = sh_count;
		repeat (3800) @(posedge clk_i);
		check("free_runs", sh_count - s0 >= 3, 1'b1);
		wb(OFS_CONTROL_A, 1'b0, 8'h00);
		check("start_held", q[6], 1'b1);
		wb(OFS_CONTROL_A, 1'b1, 8'h00);
		// Power reduction overrides enable
		wb(OFS_POWER_REDUCTION, 1'b1, 8'h01);
		wb(OFS_CONTROL_A, 1'b1, 8'h80);
		@(posedge clk_i);
		check("pr_off", power, 1'b0);
		wb(OFS_POWER_REDUCTION, 1'b1, 8'h00);
		@(posedge clk_i);
		check("pr_on", power, 1'b1);
		// Divider 7 gives ratio 256 on a first conversion
		wb(OFS_CONTROL_A, 1'b1, 8'hd7);
		wait_done(n);
		check("div_time", n >= 6401 && n <= 6656, 1'b1);
		// Reset in the middle of a conversion
		wb(OFS_CONTROL_A, 1'b1, 8'hc6);
		repeat (300) @(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check("rst_power", power, 1'b0);
		check("rst_chan", channel_select_o, 4'h0);
		wb(OFS_CONTROL_A, 1'b0, 8'h00);
		check("rst_ctrl", q, 32'h0);
		complete_run();
	end
endmodule
`default_nettype wire
